// ### design/frp_device.sv
// Flash device end: resume, power-down and identification commands
// Summary of operation
// - Accepted suspend sets suspend flag at once
// - Resume only when suspended and not busy
// - Resume clears flag, raises busy within 200ns
// - Power loss during suspend voids later resume
// - Host waits suspend latency after resume
// - Power-down needs chip select right after bit eight
// - Enter power-down within entry time
// - Powered down: only release opcode recognised
// - Always start in normal operation
// - Release: opcode, chip select high, wait release time
// - Device ID after three dummy bytes, repeated
// - Host waits release-with-ID time afterwards
// - Release opcode ignored while busy
// - 90h: address, then manufacturer and device ID
// - 92h: two bits per clock, mode Fxh
// - 94h: dummy clocks, four bits per clock
// - Address 000001h returns device ID first on 92h and 94h; 90h always starts with manufacturer ID
// - 4Bh: four dummy bytes, 64-bit unique number
`timescale 1ns/1ps
`include "frp_defines.svh"
module frp_device #(
	parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] DEV_ID = 8'h3c, // Arbitrary value
	parameter logic [63:0] UNIQUE_ID = 64'h0123456789abcdef, // Arbitrary
	parameter int PD_ENTRY_CYC = `FRP_PD_ENTRY_CYC,
	parameter int RELEASE_CYC = `FRP_RELEASE_CYC,
	parameter int RELEASE_ID_CYC = `FRP_RELEASE_ID_CYC,
	parameter int RESUME_BUSY_CYC = `FRP_RESUME_BUSY_CYC
)(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	frp_spi_if.device spi,
	input wire logic busy_i,
	input wire logic power_fail_i,
	output logic suspend_flag_o,
	output logic suspend_req_o,
	output logic resume_req_o,
	output logic busy_o,
	output logic powered_down_o
);
	localparam logic [15:0] PD_CYC = 16'(PD_ENTRY_CYC);
	localparam logic [15:0] REL_CYC = 16'(RELEASE_CYC);
	localparam logic [15:0] REL_ID_CYC = 16'(RELEASE_ID_CYC);
	localparam logic [15:0] RES_CYC = 16'(RESUME_BUSY_CYC);
	logic [5:0] pins;
	logic cs_n_f;
	logic sclk_f;
	logic [3:0] io_f;
	logic sclk_q;
	logic cs_n_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cmd_exact;
	logic engine_busy;
	logic allowed;
	logic start_out;
	frp_pkg::frp_pwr_t pwr;
	logic [15:0] pwr_cnt;
	logic [15:0] hold_cnt;
	logic [6:0] clk_cnt;
	logic [6:0] addr_last;
	logic [7:0] opcode;
	logic [7:0] next_opcode;
	logic addr_lsb;
	logic out_phase;
	logic [2:0] out_w;
	logic [63:0] out_sr;
	logic [63:0] next_out_sr;
	logic [63:0] pattern;

	if (PD_ENTRY_CYC < 1 || PD_ENTRY_CYC > 65535 || RELEASE_CYC < 1 ||
		RELEASE_CYC > 65535 || RELEASE_ID_CYC < 1 ||
		RELEASE_ID_CYC > 65535 || RESUME_BUSY_CYC < 1 ||
		RESUME_BUSY_CYC > 65535) begin : g_chk
		$error("frp_device timing counts must be 1 to 65535");
	end

	frp_sync #(
		.WIDTH(6),
		.RESET_VAL(6'h2f)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.async_i({spi.cs_n, spi.sclk, spi.io}),
		.sync_o(pins)
	);
	assign cs_n_f = pins[5];
	assign sclk_f = pins[4];
	assign io_f = pins[3:0];

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end else begin
			sclk_q <= sclk_f;
			cs_n_q <= cs_n_f;
		end
	end
	assign sclk_rise = sclk_f & ~sclk_q & ~cs_n_f;
	assign sclk_fall = ~sclk_f & sclk_q & ~cs_n_f;
	assign cs_rise = cs_n_f & ~cs_n_q;
	// Opcode-only commands count only if exactly eight clocks came
	assign cmd_exact = cs_rise & (clk_cnt == `FRP_OP_BITS);
	assign engine_busy = busy_i | (hold_cnt != 16'h0);
	assign next_opcode = {opcode[6:0], io_f[0]};
	assign allowed = (pwr == frp_pkg::PWR_NORMAL) ||
		((pwr == frp_pkg::PWR_DOWN) && (opcode == `FRP_OP_RELEASE));
	assign start_out = sclk_rise && allowed && frp_pkg::frp_is_read(opcode) &&
		(clk_cnt == frp_pkg::frp_hdr_clks(opcode) - 7'h01) &&
		!((opcode == `FRP_OP_RELEASE) && engine_busy);

	always_comb begin
		case (opcode)
			`FRP_OP_MFR_ID_DUAL: addr_last = `FRP_ADDR_LAST_DUAL;
			`FRP_OP_MFR_ID_QUAD: addr_last = `FRP_ADDR_LAST_QUAD;
			default: addr_last = `FRP_ADDR_LAST_SINGLE;
		endcase
	end

	// Every stream is widened to 64 bits so one rotator serves all
	always_comb begin
		case (opcode)
			`FRP_OP_RELEASE: pattern = {8{DEV_ID}};
			`FRP_OP_UNIQUE_ID: pattern = UNIQUE_ID;
			`FRP_OP_MFR_ID: pattern = {4{MFR_ID, DEV_ID}};
			default: begin
				if (addr_lsb) begin
					pattern = {4{DEV_ID, MFR_ID}};
				end else begin
					pattern = {4{MFR_ID, DEV_ID}};
				end
			end
		endcase
	end

	always_comb begin
		case (out_w)
			3'h2: next_out_sr = {out_sr[61:0], out_sr[63:62]};
			3'h4: next_out_sr = {out_sr[59:0], out_sr[63:60]};
			default: next_out_sr = {out_sr[62:0], out_sr[63]};
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			clk_cnt <= 7'h00;
			opcode <= 8'h00;
			addr_lsb <= 1'b0;
			out_phase <= 1'b0;
			out_w <= 3'h1;
			out_sr <= 64'h0;
		end else if (cs_n_f) begin
			clk_cnt <= 7'h00;
			out_phase <= 1'b0;
		end else if (sclk_rise) begin
			if (clk_cnt != 7'h7f) begin
				clk_cnt <= clk_cnt + 7'h01;
			end
			if (clk_cnt < `FRP_OP_BITS) begin
				opcode <= next_opcode;
			end
			if (clk_cnt == addr_last) begin
				addr_lsb <= io_f[0];
			end
			if (start_out) begin
				out_phase <= 1'b1;
				out_w <= frp_pkg::frp_width(opcode);
				out_sr <= pattern;
			end
		end else if (sclk_fall && out_phase) begin
			out_sr <= next_out_sr;
		end
	end

	// Data changes only after a falling clock edge, MSB first
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			spi.dev_io <= 4'h0;
			spi.dev_oe <= 4'h0;
		end else if (cs_n_f || !out_phase) begin
			spi.dev_oe <= 4'h0;
		end else if (sclk_fall) begin
			spi.dev_oe <= (out_w == 3'h1) ? 4'h2 : frp_pkg::frp_lanes(out_w);
			case (out_w)
				3'h2: spi.dev_io <= {2'h0, out_sr[63:62]};
				3'h4: spi.dev_io <= out_sr[63:60];
				default: spi.dev_io <= {2'h0, out_sr[63], 1'b0};
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			pwr <= frp_pkg::PWR_NORMAL;
			pwr_cnt <= 16'h0;
		end else begin
			case (pwr)
				frp_pkg::PWR_NORMAL: begin
					if (cmd_exact && opcode == `FRP_OP_PWRDOWN) begin
						pwr <= frp_pkg::PWR_ENTERING;
						pwr_cnt <= PD_CYC;
					end
				end
				frp_pkg::PWR_ENTERING: begin
					if (pwr_cnt <= 16'h1) begin
						pwr <= frp_pkg::PWR_DOWN;
					end else begin
						pwr_cnt <= pwr_cnt - 16'h1;
					end
				end
				frp_pkg::PWR_DOWN: begin
					if (cs_rise && clk_cnt >= `FRP_OP_BITS &&
						opcode == `FRP_OP_RELEASE && !engine_busy) begin
						pwr <= frp_pkg::PWR_RELEASING;
						pwr_cnt <= (clk_cnt == `FRP_OP_BITS) ? REL_CYC : REL_ID_CYC;
					end
				end
				frp_pkg::PWR_RELEASING: begin
					// Commands during the release window are dropped
					if (pwr_cnt <= 16'h1) begin
						pwr <= frp_pkg::PWR_NORMAL;
					end else begin
						pwr_cnt <= pwr_cnt - 16'h1;
					end
				end
				default: pwr <= frp_pkg::PWR_NORMAL;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			suspend_flag_o <= 1'b0;
			suspend_req_o <= 1'b0;
			resume_req_o <= 1'b0;
			hold_cnt <= 16'h0;
		end else begin
			suspend_req_o <= 1'b0;
			resume_req_o <= 1'b0;
			if (hold_cnt != 16'h0) begin
				hold_cnt <= hold_cnt - 16'h1;
			end
			// Power loss acts as a reset, so its clear wins
			if (power_fail_i) begin
				suspend_flag_o <= 1'b0;
			end else if (cmd_exact && pwr == frp_pkg::PWR_NORMAL &&
				opcode == `FRP_OP_SUSPEND && !suspend_flag_o && busy_i) begin
				suspend_flag_o <= 1'b1;
				suspend_req_o <= 1'b1;
			end else if (cmd_exact && pwr == frp_pkg::PWR_NORMAL &&
				opcode == `FRP_OP_RESUME && suspend_flag_o &&
				!engine_busy) begin
				suspend_flag_o <= 1'b0;
				resume_req_o <= 1'b1;
				hold_cnt <= RES_CYC;
			end
		end
	end

	// Busy bridges the gap until the engine reports its own busy
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			busy_o <= 1'b0;
			powered_down_o <= 1'b0;
		end else begin
			busy_o <= engine_busy;
			powered_down_o <= (pwr == frp_pkg::PWR_DOWN);
		end
	end
endmodule

// ### design/frp_defines.svh
// Opcodes, field positions and timing counts for the flash command block
`ifndef FRP_DEFINES_SVH
`define FRP_DEFINES_SVH
`define FRP_CLK_MHZ 100
`define FRP_OP_RESUME 8'h7a
`define FRP_OP_SUSPEND 8'h75
`define FRP_OP_PWRDOWN 8'hb9
`define FRP_OP_RELEASE 8'hab
`define FRP_OP_MFR_ID 8'h90
`define FRP_OP_MFR_ID_DUAL 8'h92
`define FRP_OP_MFR_ID_QUAD 8'h94
`define FRP_OP_UNIQUE_ID 8'h4b
`define FRP_OP_BITS 7'h08
`define FRP_HDR_RELEASE_ID 7'h20
`define FRP_HDR_MFR_ID 7'h20
`define FRP_HDR_MFR_ID_DUAL 7'h18
`define FRP_HDR_MFR_ID_QUAD 7'h14
`define FRP_HDR_UNIQUE_ID 7'h28
`define FRP_ADDR_LAST_SINGLE 7'h1f
`define FRP_ADDR_LAST_DUAL 7'h13
`define FRP_ADDR_LAST_QUAD 7'h11
`define FRP_MODE_HI 4'hf
`define FRP_SUSPEND_LAT_NS 20000
`define FRP_RESUME_BUSY_NS 200
`define FRP_PD_ENTRY_NS 3000
`define FRP_RELEASE_NS 3000
`define FRP_RELEASE_ID_NS 1800
`define FRP_CYC_MAX(ns) (((ns) * `FRP_CLK_MHZ) / 1000)
`define FRP_CYC_MIN(ns) (((ns) * `FRP_CLK_MHZ + 999) / 1000)
`define FRP_RESUME_BUSY_CYC `FRP_CYC_MAX(`FRP_RESUME_BUSY_NS)
`define FRP_PD_ENTRY_CYC `FRP_CYC_MAX(`FRP_PD_ENTRY_NS)
`define FRP_RELEASE_CYC `FRP_CYC_MAX(`FRP_RELEASE_NS)
`define FRP_RELEASE_ID_CYC `FRP_CYC_MAX(`FRP_RELEASE_ID_NS)
`define FRP_HOST_RELEASE_CYC `FRP_CYC_MIN(`FRP_RELEASE_NS)
`define FRP_HOST_RELEASE_ID_CYC `FRP_CYC_MIN(`FRP_RELEASE_ID_NS)
`define FRP_HOST_SUSPEND_LAT_CYC `FRP_CYC_MIN(`FRP_SUSPEND_LAT_NS)
`define FRP_SCLK_HALF_CYC 8
`define FRP_CS_GAP_CYC 8
`endif

// ### design/frp_pkg.sv
// Types and opcode decoding shared by both ends of the flash link
package frp_pkg;
`include "frp_defines.svh"
	typedef enum logic [3:0] {
		PWR_NORMAL = 4'h1,
		PWR_ENTERING = 4'h2,
		PWR_DOWN = 4'h4,
		PWR_RELEASING = 4'h8
	} frp_pwr_t;
	typedef enum logic [5:0] {
		HS_IDLE = 6'h01,
		HS_WAIT = 6'h02,
		HS_LOW = 6'h04,
		HS_HIGH = 6'h08,
		HS_TAIL = 6'h10,
		HS_GAP = 6'h20
	} frp_host_t;
	function automatic logic [6:0] frp_hdr_clks(input logic [7:0] op);
		case (op)
			`FRP_OP_RELEASE: frp_hdr_clks = `FRP_HDR_RELEASE_ID;
			`FRP_OP_MFR_ID: frp_hdr_clks = `FRP_HDR_MFR_ID;
			`FRP_OP_MFR_ID_DUAL: frp_hdr_clks = `FRP_HDR_MFR_ID_DUAL;
			`FRP_OP_MFR_ID_QUAD: frp_hdr_clks = `FRP_HDR_MFR_ID_QUAD;
			`FRP_OP_UNIQUE_ID: frp_hdr_clks = `FRP_HDR_UNIQUE_ID;
			default: frp_hdr_clks = `FRP_OP_BITS;
		endcase
	endfunction
	function automatic logic [2:0] frp_width(input logic [7:0] op);
		case (op)
			`FRP_OP_MFR_ID_DUAL: frp_width = 3'h2;
			`FRP_OP_MFR_ID_QUAD: frp_width = 3'h4;
			default: frp_width = 3'h1;
		endcase
	endfunction
	function automatic logic frp_is_read(input logic [7:0] op);
		frp_is_read = (frp_hdr_clks(op) != `FRP_OP_BITS);
	endfunction
	function automatic logic [3:0] frp_lanes(input logic [2:0] w);
		case (w)
			3'h2: frp_lanes = 4'h3;
			3'h4: frp_lanes = 4'hf;
			default: frp_lanes = 4'h1;
		endcase
	endfunction
endpackage

// ### design/frp_spi_if.sv
// Serial flash link between host controller and device
`timescale 1ns/1ps
interface frp_spi_if;
	logic cs_n;
	logic sclk;
	logic [3:0] host_io;
	logic [3:0] host_oe;
	logic [3:0] dev_io;
	logic [3:0] dev_oe;
	logic [3:0] io;
	// Pull-up when nobody drives; device wins a clash
	assign io = (dev_oe & dev_io) | (~dev_oe & host_oe & host_io) |
		(~dev_oe & ~host_oe);
	modport host(output cs_n, output sclk, output host_io, output host_oe,
		input io);
	modport device(input cs_n, input sclk, input io, output dev_io,
		output dev_oe);
endinterface

// ### design/frp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module frp_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] agree;
	if (WIDTH < 1) begin : g_chk
		$error("frp_sync width must be at least one");
	end
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			stage1 <= RESET_VAL;
			stage2 <= RESET_VAL;
			stage3 <= RESET_VAL;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end
	// Stage one is left alone; only later stages are compared
	assign agree = ~(stage2 ^ stage3);
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync_o <= RESET_VAL;
		end else begin
			sync_o <= (stage2 & agree) | (sync_o & ~agree);
		end
	end
endmodule

// ### design/frp_host.sv
// Host controller end: issues flash commands and collects read data
`timescale 1ns/1ps
`include "frp_defines.svh"
module frp_host #(
	parameter int HALF_CYC = `FRP_SCLK_HALF_CYC,
	parameter int CS_GAP_CYC = `FRP_CS_GAP_CYC,
	parameter int RELEASE_CYC = `FRP_HOST_RELEASE_CYC,
	parameter int RELEASE_ID_CYC = `FRP_HOST_RELEASE_ID_CYC,
	parameter int SUSPEND_LAT_CYC = `FRP_HOST_SUSPEND_LAT_CYC
)(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	frp_spi_if.host spi,
	input wire logic start_i,
	input wire logic [7:0] opcode_i,
	input wire logic [23:0] addr_i,
	input wire logic [7:0] mode_i,
	input wire logic [6:0] rd_clks_i,
	output logic ready_o,
	output logic done_o,
	output logic [63:0] rd_data_o
);
	frp_pkg::frp_host_t state;
	logic [3:0] io_f;
	logic [7:0] op;
	logic [55:0] tx_sr;
	logic [6:0] hdr;
	logic [7:0] tot;
	logic [7:0] clk_k;
	logic [15:0] phase_cnt;
	logic [15:0] suspend_guard;
	logic [2:0] tx_w;
	logic [2:0] rx_w;
	logic [7:0] mode_fx;
	logic [47:0] payload;

	if (HALF_CYC < 8 || HALF_CYC > 65535 || CS_GAP_CYC < 4 ||
		CS_GAP_CYC > 65535 || RELEASE_CYC < 1 || RELEASE_CYC > 65535 ||
		RELEASE_ID_CYC < 1 || RELEASE_ID_CYC > 65535 ||
		SUSPEND_LAT_CYC < 1 || SUSPEND_LAT_CYC > 65535) begin : g_chk
		$error("frp_host timing counts out of range");
	end

	frp_sync #(
		.WIDTH(4),
		.RESET_VAL(4'hf)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.async_i(spi.io),
		.sync_o(io_f)
	);

	assign mode_fx = {`FRP_MODE_HI, mode_i[3:0]};
	always_comb begin
		case (opcode_i)
			`FRP_OP_MFR_ID: payload = {addr_i, 24'h0};
			`FRP_OP_MFR_ID_DUAL: payload = {addr_i, mode_fx, 16'h0};
			`FRP_OP_MFR_ID_QUAD: payload = {16'h0, addr_i, mode_fx};
			default: payload = 48'h0;
		endcase
	end
	// Opcode always goes out one bit per clock
	assign tx_w = (clk_k < 8'h07) ? 3'h1 : frp_pkg::frp_width(op);
	assign rx_w = frp_pkg::frp_width(op);

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= frp_pkg::HS_IDLE;
			spi.cs_n <= 1'b1;
			spi.sclk <= 1'b0;
			spi.host_io <= 4'h0;
			spi.host_oe <= 4'h0;
			ready_o <= 1'b1;
			done_o <= 1'b0;
			rd_data_o <= 64'h0;
			op <= 8'h00;
			tx_sr <= 56'h0;
			hdr <= `FRP_OP_BITS;
			tot <= 8'h08;
			clk_k <= 8'h00;
			phase_cnt <= 16'h0;
		end else begin
			done_o <= 1'b0;
			if (phase_cnt != 16'h0) begin
				phase_cnt <= phase_cnt - 16'h1;
			end
			case (state)
				frp_pkg::HS_IDLE: begin
					if (start_i) begin
						ready_o <= 1'b0;
						op <= opcode_i;
						tx_sr <= {opcode_i, payload};
						// Release only: chip select rises after the opcode
						if (opcode_i == `FRP_OP_RELEASE && rd_clks_i == 7'h00) begin
							hdr <= `FRP_OP_BITS;
							tot <= 8'h08;
						end else begin
							hdr <= frp_pkg::frp_hdr_clks(opcode_i);
							tot <= {1'b0, frp_pkg::frp_hdr_clks(opcode_i)} +
								{1'b0, rd_clks_i};
						end
						state <= frp_pkg::HS_WAIT;
					end
				end
				frp_pkg::HS_WAIT: begin
					if (op != `FRP_OP_SUSPEND || suspend_guard == 16'h0) begin
						spi.cs_n <= 1'b0;
						spi.host_io <= {3'h0, tx_sr[55]};
						spi.host_oe <= 4'h1;
						tx_sr <= tx_sr << 1;
						clk_k <= 8'h00;
						rd_data_o <= 64'h0;
						phase_cnt <= 16'(HALF_CYC - 1);
						state <= frp_pkg::HS_LOW;
					end
				end
				frp_pkg::HS_LOW: begin
					if (phase_cnt == 16'h0) begin
						spi.sclk <= 1'b1;
						phase_cnt <= 16'(HALF_CYC - 1);
						state <= frp_pkg::HS_HIGH;
					end
				end
				frp_pkg::HS_HIGH: begin
					if (phase_cnt == 16'h0) begin
						// Sampled late in the high phase to cover both synchronisers
						if (clk_k >= {1'b0, hdr}) begin
							case (rx_w)
								3'h2: rd_data_o <= {rd_data_o[61:0], io_f[1:0]};
								3'h4: rd_data_o <= {rd_data_o[59:0], io_f};
								default: rd_data_o <= {rd_data_o[62:0], io_f[1]};
							endcase
						end
						spi.sclk <= 1'b0;
						clk_k <= clk_k + 8'h01;
						phase_cnt <= 16'(HALF_CYC - 1);
						if (clk_k + 8'h01 >= tot) begin
							spi.host_oe <= 4'h0;
							state <= frp_pkg::HS_TAIL;
						end else begin
							if (clk_k + 8'h01 < {1'b0, hdr}) begin
								spi.host_oe <= frp_pkg::frp_lanes(tx_w);
								case (tx_w)
									3'h2: spi.host_io <= {2'h0, tx_sr[55:54]};
									3'h4: spi.host_io <= tx_sr[55:52];
									default: spi.host_io <= {3'h0, tx_sr[55]};
								endcase
								tx_sr <= tx_sr << tx_w;
							end else begin
								spi.host_oe <= 4'h0;
							end
							state <= frp_pkg::HS_LOW;
						end
					end
				end
				frp_pkg::HS_TAIL: begin
					if (phase_cnt == 16'h0) begin
						spi.cs_n <= 1'b1;
						if (op == `FRP_OP_RELEASE && hdr == `FRP_OP_BITS) begin
							phase_cnt <= 16'(RELEASE_CYC - 1);
						end else if (op == `FRP_OP_RELEASE) begin
							phase_cnt <= 16'(RELEASE_ID_CYC - 1);
						end else begin
							phase_cnt <= 16'(CS_GAP_CYC - 1);
						end
						state <= frp_pkg::HS_GAP;
					end
				end
				frp_pkg::HS_GAP: begin
					if (phase_cnt == 16'h0) begin
						ready_o <= 1'b1;
						done_o <= 1'b1;
						state <= frp_pkg::HS_IDLE;
					end
				end
				default: state <= frp_pkg::HS_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			suspend_guard <= 16'h0;
		end else if (state == frp_pkg::HS_TAIL && phase_cnt == 16'h0 &&
			op == `FRP_OP_RESUME) begin
			suspend_guard <= 16'(SUSPEND_LAT_CYC);
		end else if (suspend_guard != 16'h0) begin
			suspend_guard <= suspend_guard - 16'h1;
		end
	end
endmodule

// ### sim/frp_link_assertions.sv
// Concurrent checks on the flash link and the device status outputs
`timescale 1ns/1ps
module frp_link_assertions #(
	parameter int PD_ENTRY_CYC = 5
)(
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] host_oe,
	input wire logic [3:0] dev_oe,
	input wire logic busy_i,
	input wire logic power_fail_i,
	input wire logic suspend_flag_o,
	input wire logic suspend_req_o,
	input wire logic resume_req_o,
	input wire logic busy_o,
	input wire logic powered_down_o
);
	int hi_cnt;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	// Saturates so a long idle link cannot wrap
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			hi_cnt <= 0;
		end else if (!cs_n) begin
			hi_cnt <= 0;
		end else if (hi_cnt < 1000) begin
			hi_cnt <= hi_cnt + 1;
		end
	end
	AST_CS_SCLK_IDLE: assert property (cs_n |-> !sclk)
		else $error("serial clock high while deselected");
	AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
		else $error("serial clock high phase wrong length");
	AST_SUSPEND_SET: assert property (suspend_req_o |-> ##[0:1] suspend_flag_o)
		else $error("suspend flag not set");
	AST_SUSPEND_COND: assert property (suspend_req_o |-> !$past(suspend_flag_o))
		else $error("suspend taken while already suspended");
	AST_RES_COND: assert property ($rose(resume_req_o) |->
		$past(suspend_flag_o) && !$past(busy_o) && !suspend_flag_o)
		else $error("resume taken in wrong state");
	AST_RES_BUSY: assert property (resume_req_o |-> ##[1:20] busy_o)
		else $error("busy not raised after resume");
	AST_PF_CLEAR: assert property (power_fail_i |=> !suspend_flag_o)
		else $error("suspend flag kept over power loss");
	AST_PD_ENTRY: assert property ($rose(powered_down_o) |-> cs_n &&
		hi_cnt >= PD_ENTRY_CYC && hi_cnt <= PD_ENTRY_CYC + 10)
		else $error("power-down entry at wrong time");
	AST_OE_RELEASE: assert property ($rose(cs_n) |-> ##[1:8] dev_oe == 4'h0)
		else $error("device still drives after deselect");
	AST_NO_CLASH: assert property ((dev_oe & host_oe) == 4'h0)
		else $error("both ends drive the same line");
	AST_BUSY_FOLLOW: assert property (busy_i |=> busy_o)
		else $error("busy output does not follow engine");
endmodule

// ### sim/flash_resume_powerdown_id_commands_tb_top.sv
// Self-checking bench: host and device ends joined over the flash link
`timescale 1ns/1ps
`include "frp_defines.svh"
`define CHK(act, exp) begin samples_checked++; \
	if ((act) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: got %h want %h", $time, act, exp); end end
module flash_resume_powerdown_id_commands_tb_top;
	localparam logic [7:0] MFR = 8'ha5; // Arbitrary value
	localparam logic [7:0] DEV = 8'hc3; // Arbitrary value
	localparam logic [63:0] UID = 64'hfedcba9876543210; // Arbitrary value
	localparam int PD_CYC = 5;
	localparam int SUSPEND_LAT = 30;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic start_i = 1'b0;
	logic [7:0] opcode_i = 8'h00;
	logic [23:0] addr_i = 24'h000000;
	logic [7:0] mode_i = 8'hf0;
	logic [6:0] rd_clks_i = 7'h00;
	logic busy_i = 1'b0;
	logic power_fail_i = 1'b0;
	logic ready_o, done_o, suspend_flag_o, suspend_req_o, resume_req_o;
	logic busy_o, powered_down_o;
	logic [63:0] rd_data_o;
	int error_cnt = 0;
	int samples_checked = 0;
	int cs_high_cyc = 0;
	int cs_gap = 0;
	// Last chip select high time, seen from the bench clock
	always @(posedge sys_clk_i) begin
		if (frp_spi_if_inst.cs_n === 1'b1) begin
			cs_high_cyc <= cs_high_cyc + 1;
		end else if (cs_high_cyc != 0) begin
			cs_gap <= cs_high_cyc;
			cs_high_cyc <= 0;
		end
	end
	always #5 sys_clk_i = ~sys_clk_i;
	frp_spi_if frp_spi_if_inst();
	// Host waits longer than the device needs, so release is never cut short
	// Guard long enough that a missing hold-off shows in the gap
	frp_host #(.RELEASE_CYC(12), .RELEASE_ID_CYC(12),
		.SUSPEND_LAT_CYC(SUSPEND_LAT))
		frp_host_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.spi(frp_spi_if_inst), .start_i(start_i), .opcode_i(opcode_i),
		.addr_i(addr_i), .mode_i(mode_i), .rd_clks_i(rd_clks_i),
		.ready_o(ready_o), .done_o(done_o), .rd_data_o(rd_data_o));
	frp_device #(.MFR_ID(MFR), .DEV_ID(DEV), .UNIQUE_ID(UID),
		.PD_ENTRY_CYC(PD_CYC), .RELEASE_CYC(5), .RELEASE_ID_CYC(5))
		frp_device_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.spi(frp_spi_if_inst), .busy_i(busy_i), .power_fail_i(power_fail_i),
		.suspend_flag_o(suspend_flag_o), .suspend_req_o(suspend_req_o),
		.resume_req_o(resume_req_o), .busy_o(busy_o),
		.powered_down_o(powered_down_o));
	frp_link_assertions #(.PD_ENTRY_CYC(PD_CYC)) frp_link_assertions_inst (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.cs_n(frp_spi_if_inst.cs_n), .sclk(frp_spi_if_inst.sclk),
		.host_oe(frp_spi_if_inst.host_oe), .dev_oe(frp_spi_if_inst.dev_oe),
		.busy_i(busy_i), .power_fail_i(power_fail_i),
		.suspend_flag_o(suspend_flag_o), .suspend_req_o(suspend_req_o),
		.resume_req_o(resume_req_o), .busy_o(busy_o),
		.powered_down_o(powered_down_o));
	task automatic end_sim();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	// Entered just after an edge; returns just after the done edge
	task automatic cmd(input logic [7:0] op, input logic [23:0] adr,
		input logic [6:0] clks);
		int n;
		n = 0;
		while (ready_o !== 1'b1 && n < 5000) begin
			wait_cyc(1);
			n++;
		end
		opcode_i = op;
		addr_i = adr;
		rd_clks_i = clks;
		start_i = 1'b1;
		wait_cyc(1);
		start_i = 1'b0;
		while (done_o !== 1'b1 && n < 5000) begin
			wait_cyc(1);
			n++;
		end
		if (n >= 5000) begin
			error_cnt++;
			$display("wrong value at %0t: command never done", $time);
			end_sim();
		end
	endtask
	task automatic t_reset_state();
		`CHK(powered_down_o, 1'b0)
		`CHK(suspend_flag_o, 1'b0)
	endtask
	task automatic t_id_reads();
		logic [7:0] op [7];
		logic [23:0] ad [7];
		logic [6:0] ck [7];
		logic [63:0] ex [7];
		op = '{`FRP_OP_RELEASE, `FRP_OP_MFR_ID, `FRP_OP_MFR_ID_DUAL,
			`FRP_OP_MFR_ID_DUAL, `FRP_OP_MFR_ID_QUAD, `FRP_OP_MFR_ID_QUAD,
			`FRP_OP_UNIQUE_ID};
		ad = '{24'h0, 24'h0, 24'h0, 24'h1, 24'h0, 24'h1, 24'h0};
		ck = '{7'h10, 7'h10, 7'h10, 7'h10, 7'h08, 7'h08, 7'h40};
		ex = '{{48'h0, DEV, DEV}, {48'h0, MFR, DEV},
			{32'h0, MFR, DEV, MFR, DEV}, {32'h0, DEV, MFR, DEV, MFR},
			{32'h0, MFR, DEV, MFR, DEV}, {32'h0, DEV, MFR, DEV, MFR}, UID};
		for (int i = 0; i < 7; i++) begin
			cmd(op[i], ad[i], ck[i]);
			`CHK(rd_data_o, ex[i])
		end
	endtask
	task automatic t_resume();
		busy_i = 1'b1;
		cmd(`FRP_OP_SUSPEND, 24'h0, 7'h0);
		`CHK(suspend_flag_o, 1'b1)
		cmd(`FRP_OP_RESUME, 24'h0, 7'h0);
		`CHK(suspend_flag_o, 1'b1)
		busy_i = 1'b0;
		wait_cyc(3);
		cmd(`FRP_OP_RESUME, 24'h0, 7'h0);
		`CHK(suspend_flag_o, 1'b0)
		`CHK(busy_o, 1'b1)
		wait_cyc(30);
		`CHK(busy_o, 1'b0)
		cmd(`FRP_OP_RESUME, 24'h0, 7'h0);
		`CHK(busy_o, 1'b0)
	endtask
	task automatic t_power_fail();
		busy_i = 1'b1;
		cmd(`FRP_OP_SUSPEND, 24'h0, 7'h0);
		`CHK(cs_gap >= SUSPEND_LAT, 1'b1)
		busy_i = 1'b0;
		`CHK(suspend_flag_o, 1'b1)
		power_fail_i = 1'b1;
		wait_cyc(1);
		power_fail_i = 1'b0;
		wait_cyc(1);
		`CHK(suspend_flag_o, 1'b0)
		cmd(`FRP_OP_RESUME, 24'h0, 7'h0);
		`CHK(busy_o, 1'b0)
	endtask
	task automatic t_powerdown();
		// Clocks beyond the opcode must void the command
		cmd(`FRP_OP_PWRDOWN, 24'h0, 7'h08);
		wait_cyc(PD_CYC + 10);
		`CHK(powered_down_o, 1'b0)
		cmd(`FRP_OP_PWRDOWN, 24'h0, 7'h0);
		wait_cyc(PD_CYC + 8);
		`CHK(powered_down_o, 1'b1)
		cmd(`FRP_OP_MFR_ID, 24'h0, 7'h10);
		`CHK(rd_data_o, 64'hffff)
		`CHK(powered_down_o, 1'b1)
		cmd(`FRP_OP_RELEASE, 24'h0, 7'h0);
		`CHK(powered_down_o, 1'b0)
		cmd(`FRP_OP_MFR_ID, 24'h0, 7'h10);
		`CHK(rd_data_o, {48'h0, MFR, DEV})
		cmd(`FRP_OP_PWRDOWN, 24'h0, 7'h0);
		wait_cyc(PD_CYC + 8);
		cmd(`FRP_OP_RELEASE, 24'h0, 7'h10);
		`CHK(rd_data_o, {48'h0, DEV, DEV})
		cmd(`FRP_OP_MFR_ID, 24'h0, 7'h10);
		`CHK(rd_data_o, {48'h0, MFR, DEV})
	endtask
	task automatic t_busy_release();
		busy_i = 1'b1;
		wait_cyc(2);
		cmd(`FRP_OP_RELEASE, 24'h0, 7'h10);
		`CHK(rd_data_o, 64'hffff)
		`CHK(busy_o, 1'b1)
		busy_i = 1'b0;
		wait_cyc(2);
	endtask
	initial begin
		repeat (5) @(posedge sys_clk_i);
		#1 reset_i = 1'b0;
		t_reset_state();
		t_id_reads();
		t_resume();
		t_power_fail();
		t_powerdown();
		t_busy_release();
		end_sim();
	end
endmodule
